// >>> include/pigfm_pkg.sv
// constants, field layout and carrier types of the microphone input and pin function mux
package pigfm_pkg;

  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam int REG_W = 8;

  // printed offsets are indices, byte address is four times
  localparam logic [APB_ADDR_W-1:0] IDX_MIC_CFG = 8'h13;
  localparam logic [APB_ADDR_W-1:0] IDX_PIN_CFG = 8'h14;
  localparam logic [APB_ADDR_W-1:0] IDX_BIAS_CFG = 8'h15;
  localparam logic [APB_ADDR_W-1:0] ADDR_MIC_CFG = 8'(IDX_MIC_CFG * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_PIN_CFG = 8'(IDX_PIN_CFG * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_BIAS_CFG = 8'(IDX_BIAS_CFG * 4);

  localparam logic [REG_W-1:0] RST_MIC_CFG = 8'h00;
  localparam logic [REG_W-1:0] RST_PIN_CFG = 8'h00;
  localparam logic [REG_W-1:0] RST_BIAS_CFG = 8'h00;

  // microphone_input_config fields
  localparam int BIT_TYPE_A = 7;
  localparam int BIT_TYPE_B = 6;
  localparam int BIT_EDGE_A = 5;
  localparam int BIT_EDGE_B = 4;
  localparam int SRC_A_LO = 2;
  localparam int SRC_B_LO = 0;
  // pin_function_config fields
  localparam int BIT_OVRD = 7;
  localparam int BIT_SHARED = 6;
  localparam int ADC_PD_LO = 4;
  localparam int DAC_PD_LO = 2;
  localparam int BIT_POWER_LIMIT = 1;
  localparam int BIT_AMP = 0;
  // bias_pin_config fields
  localparam int BIAS_SRC_LO = 6;
  localparam logic [5:0] BIAS_RSVD_READ = 6'h00;

  localparam int MIC_CLK_HALF_DEF = 50;
  localparam int MIC_DIV_W = 8;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_PIN_ONE = 2'b01,
    SRC_PIN_TWO = 2'b10,
    SRC_INPUT_ONLY = 2'b11
  } pigfm_src_type;

  typedef struct packed {
    logic gp1;
    logic gp2;
    logic gpi;
    logic din;
    logic dout;
  } pigfm_pins_type;

  typedef struct packed {
    logic adc_powerdown;
    logic dac_powerdown;
    logic power_limit;
    logic amp_control;
    logic microphone_bias;
  } pigfm_power_type;

endpackage

// >>> hdl/pigfm_sync.sv
// two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module pigfm_sync #(
  parameter int W = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// >>> hdl/pigfm_src_sel.sv
// four-way pin source selector with optional data-in substitution
`timescale 1ns/1ps
module pigfm_src_sel (
  input wire pigfm_pkg::pigfm_src_type code,
  input wire pigfm_pkg::pigfm_pins_type pins,
  input wire logic override,
  output logic sel
);
  import pigfm_pkg::*;

  always_comb begin
    case (code)
      SRC_PIN_ONE: sel = pins.gp1;
      SRC_PIN_TWO: sel = pins.gp2;
      SRC_INPUT_ONLY: sel = override ? pins.din : pins.gpi;
      default: sel = 1'b0;
    endcase
  end
endmodule

// >>> hdl/pigfm_top.sv
// microphone input routing, edge sampling and pin-driven power controls behind an APB slave
`timescale 1ns/1ps
module pigfm_top #(
  parameter int MIC_CLK_HALF = pigfm_pkg::MIC_CLK_HALF_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [pigfm_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pigfm_pkg::APB_DATA_W-1:0] pwdata,
  output logic pready,
  output logic [pigfm_pkg::APB_DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic general_pin_one,
  input wire logic general_pin_two,
  input wire logic input_only_general_pin,
  input wire logic serial_din_pin,
  input wire logic data_out_pin_in,
  output logic data_out_pin_out,
  output logic data_out_pin_oe,
  input wire logic asi_serial_out,
  input wire logic asi_serial_out_en,
  input wire logic dout_func_out,
  input wire logic dout_func_oe,
  output logic asi_serial_din,
  input wire logic adc_register_power_control,
  input wire logic dac_register_power_control,
  output pigfm_pkg::pigfm_power_type power_ctl,
  output logic microphone_clock_out,
  output logic [3:0] mic_data,
  output logic [3:0] mic_strobe
);
  import pigfm_pkg::*;

  logic [REG_W-1:0] mic_cfg;
  logic [REG_W-1:0] pin_cfg;
  logic [1:0] bias_src;
  logic [REG_W-1:0] next_mic_cfg;
  logic [REG_W-1:0] next_pin_cfg;
  logic [1:0] next_bias_src;
  logic next_pready;
  logic [APB_DATA_W-1:0] next_prdata;
  logic next_pslverr;
  logic wr_en;

  // ---------------- register bus ----------------
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    next_mic_cfg = mic_cfg;
    next_pin_cfg = pin_cfg;
    next_bias_src = bias_src;
    next_pready = psel && !penable;
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (wr_en) begin
      if (paddr == ADDR_MIC_CFG) begin
        next_mic_cfg = pwdata[REG_W-1:0];
      end else if (paddr == ADDR_PIN_CFG) begin
        next_pin_cfg = pwdata[REG_W-1:0];
      end else if (paddr == ADDR_BIAS_CFG) begin
        // reserved low bits are not stored
        next_bias_src = pwdata[BIAS_SRC_LO+1:BIAS_SRC_LO];
      end
    end
    if (psel && !penable) begin
      if (paddr == ADDR_MIC_CFG) begin
        next_prdata[REG_W-1:0] = mic_cfg;
      end else if (paddr == ADDR_PIN_CFG) begin
        next_prdata[REG_W-1:0] = pin_cfg;
      end else if (paddr == ADDR_BIAS_CFG) begin
        next_prdata[REG_W-1:0] = {bias_src, BIAS_RSVD_READ};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mic_cfg <= RST_MIC_CFG;
      pin_cfg <= RST_PIN_CFG;
      bias_src <= RST_BIAS_CFG[BIAS_SRC_LO+1:BIAS_SRC_LO];
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      mic_cfg <= next_mic_cfg;
      pin_cfg <= next_pin_cfg;
      bias_src <= next_bias_src;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ---------------- pin capture and source selection ----------------
  pigfm_pins_type pins_raw;
  pigfm_pins_type pins_s;
  logic line_a;
  logic line_b;
  logic adc_pin;
  logic dac_pin;
  logic bias_pin;
  logic ovrd;

  assign pins_raw = '{gp1: general_pin_one, gp2: general_pin_two, gpi: input_only_general_pin,
                      din: serial_din_pin, dout: data_out_pin_in};
  assign ovrd = pin_cfg[BIT_OVRD];

  // pads are asynchronous to the device clock
  pigfm_sync #(.W($bits(pigfm_pins_type))) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  pigfm_src_sel u_sel_line_a (
    .code(pigfm_src_type'(mic_cfg[SRC_A_LO+1:SRC_A_LO])),
    .pins(pins_s),
    .override(ovrd),
    .sel(line_a)
  );
  pigfm_src_sel u_sel_line_b (
    .code(pigfm_src_type'(mic_cfg[SRC_B_LO+1:SRC_B_LO])),
    .pins(pins_s),
    .override(ovrd),
    .sel(line_b)
  );
  // control pins never take the data-in substitution
  pigfm_src_sel u_sel_adc (
    .code(pigfm_src_type'(pin_cfg[ADC_PD_LO+1:ADC_PD_LO])),
    .pins(pins_s),
    .override(1'b0),
    .sel(adc_pin)
  );
  pigfm_src_sel u_sel_dac (
    .code(pigfm_src_type'(pin_cfg[DAC_PD_LO+1:DAC_PD_LO])),
    .pins(pins_s),
    .override(1'b0),
    .sel(dac_pin)
  );
  pigfm_src_sel u_sel_bias (
    .code(pigfm_src_type'(bias_src)),
    .pins(pins_s),
    .override(1'b0),
    .sel(bias_pin)
  );

  // ---------------- power and pin functions ----------------
  pigfm_power_type next_power;
  logic next_dout_out;
  logic next_dout_oe;
  logic next_asi_din;

  always_comb begin
    // register controls are active-high power-up enables
    next_power.adc_powerdown = adc_pin || !adc_register_power_control;
    next_power.dac_powerdown = dac_pin || !dac_register_power_control;
    next_power.power_limit = pin_cfg[BIT_POWER_LIMIT] && pins_s.gp1;
    next_power.amp_control = pin_cfg[BIT_AMP] && pins_s.gp1;
    next_power.microphone_bias = bias_pin;
    if (pin_cfg[BIT_SHARED]) begin
      // pin turns round whenever the serial port stops driving
      next_dout_out = asi_serial_out;
      next_dout_oe = asi_serial_out_en;
      next_asi_din = pins_s.dout;
    end else begin
      next_dout_out = dout_func_out;
      next_dout_oe = dout_func_oe;
      next_asi_din = pins_s.din;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_ctl <= '0;
      data_out_pin_out <= 1'b0;
      data_out_pin_oe <= 1'b0;
      asi_serial_din <= 1'b0;
    end else begin
      power_ctl <= next_power;
      data_out_pin_out <= next_dout_out;
      data_out_pin_oe <= next_dout_oe;
      asi_serial_din <= next_asi_din;
    end
  end

  // ---------------- microphone clock and edge sampling ----------------
  logic [MIC_DIV_W-1:0] div_cnt;
  logic [MIC_DIV_W-1:0] next_div_cnt;
  logic next_mic_clk;
  logic tick;
  logic rise_evt;
  logic fall_evt;
  logic [3:0] chan_en;
  logic [3:0] samp;
  logic [3:0] next_mic_data;
  logic [3:0] next_mic_strobe;

  assign tick = div_cnt == MIC_DIV_W'(MIC_CLK_HALF - 1);
  assign rise_evt = tick && !microphone_clock_out;
  assign fall_evt = tick && microphone_clock_out;

  always_comb begin
    next_div_cnt = tick ? '0 : div_cnt + 1'b1;
    next_mic_clk = tick ? !microphone_clock_out : microphone_clock_out;
    // other record-type values are reserved, so channel 1 (type A) or channel 2 (type B) of line A stays idle; line B channels ignore both type bits
    chan_en[0] = mic_cfg[BIT_TYPE_A] && (mic_cfg[SRC_A_LO+1:SRC_A_LO] != SRC_NONE);
    chan_en[1] = mic_cfg[BIT_TYPE_B] && (mic_cfg[SRC_A_LO+1:SRC_A_LO] != SRC_NONE);
    chan_en[2] = mic_cfg[SRC_B_LO+1:SRC_B_LO] != SRC_NONE;
    chan_en[3] = chan_en[2];
    samp[0] = mic_cfg[BIT_EDGE_A] ? rise_evt : fall_evt;
    samp[1] = mic_cfg[BIT_EDGE_A] ? fall_evt : rise_evt;
    samp[2] = mic_cfg[BIT_EDGE_B] ? rise_evt : fall_evt;
    samp[3] = mic_cfg[BIT_EDGE_B] ? fall_evt : rise_evt;
    next_mic_strobe = samp & chan_en;
    next_mic_data = mic_data;
    for (int i = 0; i < 4; i++) begin
      if (next_mic_strobe[i]) begin
        next_mic_data[i] = (i < 2) ? line_a : line_b;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      microphone_clock_out <= 1'b0;
      mic_data <= '0;
      mic_strobe <= '0;
    end else begin
      div_cnt <= next_div_cnt;
      microphone_clock_out <= next_mic_clk;
      mic_data <= next_mic_data;
      mic_strobe <= next_mic_strobe;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_ch1_fall_on_rise;
    rise_evt && mic_cfg[BIT_EDGE_A] && chan_en[0];
  endsequence
  sequence s_ch1_fall_default;
    fall_evt && !mic_cfg[BIT_EDGE_A] && chan_en[0];
  endsequence
  sequence s_bias_read;
    psel && !penable && !pwrite && paddr == ADDR_BIAS_CFG;
  endsequence

  a_chan_a_type: assert property (mic_strobe[0] |-> $past(mic_cfg[BIT_TYPE_A]))
    else $error("channel 1 sampled without digital type");
  a_chan_b_type: assert property (mic_strobe[1] |-> $past(mic_cfg[BIT_TYPE_B]))
    else $error("channel 2 sampled without digital type");
  a_line_a_edge: assert property ((s_ch1_fall_on_rise or s_ch1_fall_default) |=> mic_strobe[0]
                                  ##1 !mic_strobe[0])
    else $error("channel 1 not sampled on its selected edge");
  a_line_b_edge: assert property (mic_strobe[2] |-> $past(mic_cfg[BIT_EDGE_B] ? rise_evt : fall_evt))
    else $error("channel 3 sampled on wrong edge");
  a_line_a_data: assert property (mic_strobe[0] |-> mic_data[0] == $past(line_a))
    else $error("channel 1 data not from selected source");
  a_line_b_off: assert property (mic_cfg[SRC_B_LO+1:SRC_B_LO] == SRC_NONE |=> mic_strobe[3:2] == 2'b00)
    else $error("disabled line B produced samples");
  a_src_override: assert property (ovrd && mic_cfg[SRC_A_LO+1:SRC_A_LO] == SRC_INPUT_ONLY
                                   |-> line_a == pins_s.din)
    else $error("override did not substitute data-in");
  a_shared_pin: assert property (pin_cfg[BIT_SHARED] |=> asi_serial_din == $past(pins_s.dout)
                                 && data_out_pin_oe == $past(asi_serial_out_en))
    else $error("shared data pin routing wrong");
  a_adc_powerdown: assert property (power_ctl.adc_powerdown == $past(adc_pin || !adc_register_power_control))
    else $error("adc power-down mismatch");
  a_dac_powerdown: assert property (power_ctl.dac_powerdown == $past(dac_pin || !dac_register_power_control))
    else $error("dac power-down mismatch");
  a_power_limit_pin: assert property (!pin_cfg[BIT_POWER_LIMIT] |=> !power_ctl.power_limit)
    else $error("power limit active while pin function off");
  a_amp_pin: assert property (pin_cfg[BIT_AMP] && pins_s.gp1 |=> power_ctl.amp_control)
    else $error("amp control did not follow pin one");
  a_bias_pin: assert property (bias_src == SRC_NONE |=> !power_ctl.microphone_bias)
    else $error("bias enabled with no pin selected");
  a_bias_rsvd_zero: assert property (s_bias_read |=> prdata[5:0] == BIAS_RSVD_READ && pready)
    else $error("reserved bias bits not read as zero");
  // second channel of line A, type gating of channel 1, line B data and the remaining pin paths
  a_chan_b_edge: assert property (mic_strobe[1] |-> $past(mic_cfg[BIT_EDGE_A] ? fall_evt : rise_evt))
    else $error("channel 2 sampled on wrong edge");
  a_type_a_off: assert property (!mic_cfg[BIT_TYPE_A] |=> !mic_strobe[0])
    else $error("reserved record type still sampled");
  a_line_b_data: assert property (mic_strobe[2] |-> mic_data[2] == $past(line_b))
    else $error("channel 3 data not from selected source");
  a_power_limit_follow: assert property (pin_cfg[BIT_POWER_LIMIT] && pins_s.gp1 |=> power_ctl.power_limit)
    else $error("power limit did not follow pin one");
  a_bias_follow: assert property (bias_pin |=> power_ctl.microphone_bias)
    else $error("bias enable did not follow selected pin");
  a_din_direct: assert property (!pin_cfg[BIT_SHARED] |=> asi_serial_din == $past(pins_s.din))
    else $error("serial data-in not from its own pin");
endmodule

// >>> bench/pigfm_pin_model.sv
// board model: microphone data lines and control pins around the mux
`timescale 1ns/1ps
module pigfm_pin_model (
  input wire pigfm_pkg::pigfm_pins_type lvl,
  input wire logic data_out_pin_out,
  input wire logic data_out_pin_oe,
  output logic general_pin_one,
  output logic general_pin_two,
  output logic input_only_general_pin,
  output logic serial_din_pin,
  output logic data_out_pin_in
);
  import pigfm_pkg::*;
  // a high level is the asserted request on every control pin
  assign general_pin_one = lvl.gp1;
  assign general_pin_two = lvl.gp2;
  assign input_only_general_pin = lvl.gpi;
  assign serial_din_pin = lvl.din;
  // device drive wins on the pad, otherwise the board level shows
  assign data_out_pin_in = data_out_pin_oe ? data_out_pin_out : lvl.dout;
endmodule

// >>> bench/testbench.sv
// register, routing and pin-control tests of the microphone and pin function mux
`timescale 1ns/1ps
module testbench;
  import pigfm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_DATA_W-1:0] pwdata = 32'h0;
  logic [APB_DATA_W-1:0] prdata;
  logic pready, pslverr;
  pigfm_pins_type lvl = 5'h00;
  logic gp1, gp2, gpi, din, dout_in, dout_out, dout_oe, asi_din, mclk;
  logic asi_out = 1'b0, asi_en = 1'b0, func_out = 1'b0, func_oe = 1'b0, adc_on = 1'b1, dac_on = 1'b1;
  pigfm_power_type pwr;
  logic [3:0] mdata, mstb;
  int n_fail = 0;
  int cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  pigfm_top #(.MIC_CLK_HALF(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .general_pin_one(gp1), .general_pin_two(gp2), .input_only_general_pin(gpi), .serial_din_pin(din),
    .data_out_pin_in(dout_in), .data_out_pin_out(dout_out), .data_out_pin_oe(dout_oe),
    .asi_serial_out(asi_out), .asi_serial_out_en(asi_en), .dout_func_out(func_out), .dout_func_oe(func_oe),
    .asi_serial_din(asi_din), .adc_register_power_control(adc_on), .dac_register_power_control(dac_on),
    .power_ctl(pwr), .microphone_clock_out(mclk), .mic_data(mdata), .mic_strobe(mstb));
  pigfm_pin_model board_u (.lvl(lvl), .data_out_pin_out(dout_out), .data_out_pin_oe(dout_oe),
    .general_pin_one(gp1), .general_pin_two(gp2), .input_only_general_pin(gpi), .serial_din_pin(din),
    .data_out_pin_in(dout_in));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what = "value");
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic give_up(input string what);
    n_fail++;
    $display("CHECK FAILED at %0t: no %s in time", $time, what);
    conclude();
  endtask
  // request held until pready is seen high at a rising edge; reads there see the sampled values
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat,
                     output logic err);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) give_up("pready");
    rdat = prdata;
    err = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk(e, exp_err, "slave error");
  endtask
  // covers two sync flops plus the output register
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // the first strobe after a change may carry a stale sample, so the second is judged
  task automatic mic(input int ch, input logic clk_exp, input logic d_exp);
    int i;
    repeat (2) begin
      for (i = 0; i < 40; i++) begin
        @(negedge clk_sys);
        if (mstb[ch] === 1'b1) break;
      end
      if (i == 40) give_up("strobe");
    end
    chk(mclk, clk_exp, "mic clock level");
    chk(mdata[ch], d_exp, "mic data");
  endtask
  task automatic quiet(input logic [3:0] mask);
    settle();
    repeat (20) begin
      @(negedge clk_sys);
      chk(mstb & mask, 4'h0, "unexpected strobe");
    end
  endtask
  function automatic pigfm_pins_type sel_pins(input logic [1:0] c);
    return {c == 2'd1, c == 2'd2, c == 2'd3, 2'b00};
  endfunction
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_MIC_CFG, 32'h0, 1'b0);
    rd(ADDR_PIN_CFG, 32'h0, 1'b0);
    rd(ADDR_BIAS_CFG, 32'h0, 1'b0);
    rd(8'h58, 32'h0, 1'b1);
    // reserved bits are written only with their reset value
    wr(ADDR_BIAS_CFG, 8'hC0);
    rd(ADDR_BIAS_CFG, 32'hC0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_PIN_CFG, {2'b00, 2'(c), 2'(c), 2'b00});
      wr(ADDR_BIAS_CFG, {2'(c), 6'h00});
      lvl <= sel_pins(2'(c));
      settle();
      chk(pwr.adc_powerdown, c != 0);
      chk(pwr.dac_powerdown, c != 0);
      chk(pwr.microphone_bias, c != 0);
      @(posedge clk_sys);
      lvl <= sel_pins(2'(c)) ^ 5'b11100;
      settle();
      chk({pwr.adc_powerdown, pwr.dac_powerdown, pwr.microphone_bias}, 3'b000);
    end
    wr(ADDR_BIAS_CFG, 8'h00);
    wr(ADDR_PIN_CFG, 8'h03);
    lvl <= 5'b10000;
    settle();
    chk({pwr.power_limit, pwr.amp_control}, 2'b11);
    wr(ADDR_PIN_CFG, 8'h00);
    settle();
    chk({pwr.power_limit, pwr.amp_control}, 2'b00);
    @(posedge clk_sys);
    adc_on <= 1'b0;
    dac_on <= 1'b0;
    settle();
    chk({pwr.adc_powerdown, pwr.dac_powerdown}, 2'b11);
    @(posedge clk_sys);
    adc_on <= 1'b1;
    dac_on <= 1'b1;
    asi_en <= 1'b1;
    func_out <= 1'b1;
    lvl <= 5'b00001;
    wr(ADDR_PIN_CFG, 8'h40);
    settle();
    chk({dout_out, dout_oe}, 2'b01);
    @(posedge clk_sys);
    asi_en <= 1'b0;
    settle();
    chk(asi_din, 1'b1);
    wr(ADDR_PIN_CFG, 8'h00);
    settle();
    chk({dout_out, dout_oe}, 2'b10);
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_MIC_CFG, {4'b1100, 2'(c), 2'(c)});
      lvl <= sel_pins(2'(c));
      mic(0, 1'b0, 1'b1);
      mic(1, 1'b1, 1'b1);
      mic(2, 1'b0, 1'b1);
      mic(3, 1'b1, 1'b1);
      @(posedge clk_sys);
      lvl <= sel_pins(2'(c)) ^ 5'b11100;
      mic(0, 1'b0, 1'b0);
      mic(2, 1'b0, 1'b0);
    end
    wr(ADDR_MIC_CFG, 8'hF5);
    lvl <= 5'b10000;
    mic(0, 1'b1, 1'b1);
    mic(1, 1'b0, 1'b1);
    mic(2, 1'b1, 1'b1);
    mic(3, 1'b0, 1'b1);
    wr(ADDR_MIC_CFG, 8'hCF);
    lvl <= 5'b00100;
    mic(0, 1'b0, 1'b1);
    wr(ADDR_PIN_CFG, 8'h80);
    mic(0, 1'b0, 1'b0);
    mic(2, 1'b0, 1'b0);
    @(posedge clk_sys);
    lvl <= 5'b00010;
    mic(0, 1'b0, 1'b1);
    mic(3, 1'b1, 1'b1);
    wr(ADDR_PIN_CFG, 8'h00);
    wr(ADDR_MIC_CFG, 8'h05);
    lvl <= 5'b10000;
    quiet(4'b0011);
    mic(2, 1'b0, 1'b1);
    wr(ADDR_MIC_CFG, 8'hC0);
    quiet(4'b1111);
    conclude();
  end
endmodule
